// ==== pkg/bit_test_defs.vh ====
`ifndef BIT_TEST_DEFS_VH
`define BIT_TEST_DEFS_VH

// opcodes and prebyte
`define OP_BRANCH_BITS_SET_DIR   8'h12
`define OP_BRANCH_BITS_CLEAR_DIR 8'h13
`define OP_SET_MEM_BITS_DIR      8'h14
`define OP_SET_MEM_BITS_IDX      8'h1c
`define OP_BRANCH_BITS_SET_IDX   8'h1e
`define OP_BRANCH_BITS_CLEAR_IDX 8'h1f
`define OP_Y_PREBYTE             8'h18
`define OP_BRANCH_ALWAYS         8'h20
`define OP_BRANCH_NEVER          8'h21

// address arithmetic
`define DUMMY_ADDR               16'hffff
`define BIT_TEST_PC_ADVANCE      16'h0004
`define NEVER_PC_ADVANCE         16'h0002
`define DIRECT_PAGE_HI           8'h00

// condition code bit positions and reset value
`define CCR_N_BIT                3
`define CCR_Z_BIT                2
`define CCR_V_BIT                1
`define CCR_RESET                8'hd0

`endif

// ==== src/branch_target_calc.v ====
`timescale 1ns/1ps
`default_nettype none

// adds a signed displacement to an advanced program counter
module branch_target_calc
(
  input  wire [15:0] base_pc,
  input  wire [7:0]  displacement,
  output wire [15:0] target
);

  // sign extension of the displacement byte
  assign target = base_pc + {{8{displacement[7]}}, displacement}; // [RL14]

endmodule // branch_target_calc

`default_nettype wire

// ==== src/mask_test_unit.v ====
`timescale 1ns/1ps
`default_nettype none

// mask tests for the bit-test branches and the bit-set result with its flags
module mask_test_unit
(
  input  wire [7:0] operand,
  input  wire [7:0] mask,
  output wire       bits_clear_hit,
  output wire       bits_set_hit,
  output wire [7:0] set_result,
  output wire       result_negative,
  output wire       result_zero
);

  // branch conditions and or-merge
  assign bits_clear_hit  = ((operand & mask) == 8'h00);  // [RL1]
  assign bits_set_hit    = ((~operand & mask) == 8'h00); // [RL2]
  assign set_result      = operand | mask;               // [RL10]
  assign result_negative = set_result[7];                // [RL12]
  assign result_zero     = (set_result == 8'h00);        // [RL12]

endmodule // mask_test_unit

`default_nettype wire

// ==== src/bit_test_branch_exec.v ====
// Notes on behaviour
// RL1: branch_bits_clear ands operand with mask and branches to op+4+offset only if zero, no flags.
// RL2: branch_bits_set ands the inverted operand with mask, branches if zero, no flags touched.
// RL3: branch_bits_clear is 13 direct, 1f x-indexed, prebyte 18 then 1f y-indexed; bytes addr, mask, rel.
// RL4: branch_bits_set is 12 direct, 1e x-indexed, prebyte 18 then 1e y-indexed, same byte order.
// RL5: bit-test branches take 6, 7 or 8 all-read cycles; direct is op, dd, 00dd, mask, rel, ffff.
// RL6: indexed forms read offset, dummy ffff, operand at index+offset, mask, rel, then a dummy ffff.
// RL7: branch_never never branches, advances pc by 2 in three cycles with flags unchanged.
// RL8: branch_never reads opcode, displacement at the next address, then a dummy read at ffff.
// RL9: branch_never is 21, the complement of branch_always 20, so only the opcode differs.
// RL10: set_mem_bits ors the mask into memory and writes back; the mask is the last byte.
// RL11: in y-indexed mode the mask comes from pc+3 because of the prebyte.
// RL12: after set_mem_bits n follows bit 7, z is set for a zero result, v is cleared.
// RL13: set_mem_bits is 14 direct, 1c x-indexed, prebyte 18 then 1c, ending with a write cycle.
// RL14: the displacement is a signed byte added to the advanced program counter.
`timescale 1ns/1ps
`default_nettype none
`include "bit_test_defs.vh"

module bit_test_branch_exec
(
  input  wire        ref_clk,
  input  wire        rst,
  input  wire [15:0] start_pc,
  input  wire [15:0] index_x,
  input  wire [15:0] index_y,
  input  wire [7:0]  ccr_in,
  input  wire        start,
  input  wire [7:0]  mem_rdata,
  output reg  [15:0] mem_addr,
  output reg  [7:0]  mem_wdata,
  output reg         mem_read_write,
  output reg  [15:0] pc_out,
  output reg  [7:0]  condition_code_reg,
  output wire        busy,
  output reg         done,
  output reg         illegal_op
);

  // sequencer states
  localparam [3:0] ST_IDLE     = 4'h0;
  localparam [3:0] ST_OPCODE   = 4'h1;
  localparam [3:0] ST_PAGE2    = 4'h2;
  localparam [3:0] ST_ADDR     = 4'h3;
  localparam [3:0] ST_IDX_DUMY = 4'h4;
  localparam [3:0] ST_OPERAND  = 4'h5;
  localparam [3:0] ST_MASK     = 4'h6;
  localparam [3:0] ST_REL      = 4'h7;
  localparam [3:0] ST_END_DUMY = 4'h8;
  localparam [3:0] ST_WRITE    = 4'h9;
  localparam [3:0] ST_NEVER_RL = 4'ha;
  localparam [3:0] ST_FINISH   = 4'hb;

  // instruction kinds
  localparam [1:0] K_CLEAR = 2'd0;
  localparam [1:0] K_SET   = 2'd1;
  localparam [1:0] K_SET_MEM_BITS  = 2'd2;

  // addressing modes
  localparam [1:0] M_DIRECT = 2'd0;
  localparam [1:0] M_X      = 2'd1;
  localparam [1:0] M_Y      = 2'd2;

  reg  [3:0]  state;
  reg  [15:0] op_pc;
  reg  [15:0] fetch_pc;
  reg  [1:0]  kind;
  reg  [1:0]  mode;
  reg  [7:0]  offset;
  reg  [7:0]  operand;
  reg  [7:0]  mask;
  reg  [15:0] ea;

  wire [15:0] target;
  wire        clear_hit;
  wire        set_hit;
  wire [7:0]  set_result;
  wire        res_n;
  wire        res_z;

  assign busy = (state != ST_IDLE);

  // relative target from the opcode address plus four
  branch_target_calc u_target
  (
    .base_pc      (op_pc + `BIT_TEST_PC_ADVANCE),
    .displacement (mem_rdata),
    .target       (target)
  );

  // mask tests on the captured operand and mask
  mask_test_unit u_mask
  (
    .operand         (operand),
    .mask            (mask),
    .bits_clear_hit  (clear_hit),
    .bits_set_hit    (set_hit),
    .set_result      (set_result),
    .result_negative (res_n),
    .result_zero     (res_z)
  );

  // bus address and direction for the current state
  always @*
  begin
    mem_addr       = fetch_pc;
    mem_wdata      = set_result;
    mem_read_write = 1'b1;
    case (state)
      ST_IDX_DUMY: mem_addr = `DUMMY_ADDR; // [RL6]
      ST_END_DUMY: mem_addr = `DUMMY_ADDR; // [RL5] [RL6] [RL8]
      ST_OPERAND:  mem_addr = ea;
      ST_WRITE:
      begin
        mem_addr       = ea;
        mem_read_write = 1'b0; // [RL13]
      end
      ST_IDLE:     mem_addr = `DUMMY_ADDR;
      ST_FINISH:   mem_addr = `DUMMY_ADDR;
      default:     mem_addr = fetch_pc;
    endcase
  end

  // instruction sequencer
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      state              <= ST_IDLE;
      op_pc              <= 16'h0000;
      fetch_pc           <= 16'h0000;
      kind               <= K_CLEAR;
      mode               <= M_DIRECT;
      offset             <= 8'h00;
      operand            <= 8'h00;
      mask               <= 8'h00;
      ea                 <= 16'h0000;
      pc_out             <= 16'h0000;
      condition_code_reg <= `CCR_RESET;
      done               <= 1'b0;
      illegal_op         <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          if (start)
          begin
            state              <= ST_OPCODE;
            op_pc              <= start_pc;
            fetch_pc           <= start_pc;
            condition_code_reg <= ccr_in;
            illegal_op         <= 1'b0;
          end
        end
        ST_OPCODE:
        begin
          fetch_pc <= fetch_pc + 16'h0001;
          state    <= ST_ADDR;
          mode     <= M_DIRECT;
          case (mem_rdata) // [RL3] [RL4] [RL13]
            `OP_BRANCH_BITS_CLEAR_DIR: kind <= K_CLEAR;
            `OP_BRANCH_BITS_SET_DIR:   kind <= K_SET;
            `OP_SET_MEM_BITS_DIR:      kind <= K_SET_MEM_BITS;
            `OP_BRANCH_BITS_CLEAR_IDX:
            begin
              kind <= K_CLEAR;
              mode <= M_X;
            end
            `OP_BRANCH_BITS_SET_IDX:
            begin
              kind <= K_SET;
              mode <= M_X;
            end
            `OP_SET_MEM_BITS_IDX:
            begin
              kind <= K_SET_MEM_BITS;
              mode <= M_X;
            end
            `OP_Y_PREBYTE: state <= ST_PAGE2;
            `OP_BRANCH_NEVER: state <= ST_NEVER_RL; // [RL9]
            default:
            begin
              illegal_op <= 1'b1;
              pc_out     <= op_pc;
              state      <= ST_FINISH;
            end
          endcase
        end
        ST_PAGE2:
        begin
          fetch_pc <= fetch_pc + 16'h0001;
          mode     <= M_Y;
          state    <= ST_ADDR;
          case (mem_rdata) // [RL3] [RL4] [RL13]
            `OP_BRANCH_BITS_CLEAR_IDX: kind <= K_CLEAR;
            `OP_BRANCH_BITS_SET_IDX:   kind <= K_SET;
            `OP_SET_MEM_BITS_IDX:      kind <= K_SET_MEM_BITS;
            default:
            begin
              illegal_op <= 1'b1;
              pc_out     <= op_pc;
              state      <= ST_FINISH;
            end
          endcase
        end
        ST_ADDR:
        begin
          // address or offset byte is the first operand byte
          fetch_pc <= fetch_pc + 16'h0001;
          offset   <= mem_rdata;
          if (mode == M_DIRECT)
          begin
            ea    <= {`DIRECT_PAGE_HI, mem_rdata}; // [RL5]
            state <= ST_OPERAND;
          end
          else
          begin
            ea    <= ((mode == M_Y) ? index_y : index_x) + {8'h00, mem_rdata}; // [RL6]
            state <= ST_IDX_DUMY;
          end
        end
        ST_IDX_DUMY:
          state <= ST_OPERAND; // [RL6]
        ST_OPERAND:
        begin
          operand <= mem_rdata;
          state   <= ST_MASK;
        end
        ST_MASK:
        begin
          // mask sits at pc+2, or pc+3 behind the prebyte
          mask     <= mem_rdata; // [RL11]
          fetch_pc <= fetch_pc + 16'h0001;
          state    <= (kind == K_SET_MEM_BITS) ? ST_END_DUMY : ST_REL;
        end
        ST_REL:
        begin
          fetch_pc <= fetch_pc + 16'h0001;
          // op_pc counts from the prebyte, so the y form adds one more
          if (((kind == K_CLEAR) && clear_hit) || ((kind == K_SET) && set_hit))
            pc_out <= target + ((mode == M_Y) ? 16'h0001 : 16'h0000); // [RL1] [RL2]
          else
            pc_out <= fetch_pc + 16'h0001;
          state <= ST_END_DUMY;
        end
        ST_END_DUMY:
        begin
          if (kind == K_SET_MEM_BITS)
            state <= ST_WRITE;
          else
            state <= ST_FINISH;
        end
        ST_WRITE:
        begin
          // write-back cycle, flags follow the result
          condition_code_reg[`CCR_N_BIT] <= res_n; // [RL12]
          condition_code_reg[`CCR_Z_BIT] <= res_z; // [RL12]
          condition_code_reg[`CCR_V_BIT] <= 1'b0;  // [RL12]
          pc_out <= fetch_pc;
          state  <= ST_FINISH;
        end
        ST_NEVER_RL:
        begin
          // displacement read and dropped, flags untouched
          pc_out   <= op_pc + `NEVER_PC_ADVANCE; // [RL7]
          fetch_pc <= fetch_pc + 16'h0001;       // [RL8]
          kind     <= K_CLEAR;
          state    <= ST_END_DUMY;
        end
        ST_FINISH:
        begin
          done  <= 1'b1;
          state <= ST_IDLE;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

endmodule // bit_test_branch_exec

`default_nettype wire

// ==== verif/bit_test_branch_exec_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module bit_test_branch_exec_properties
(
  input wire        ref_clk,
  input wire        rst,
  input wire [15:0] start_pc,
  input wire [15:0] index_x,
  input wire [15:0] index_y,
  input wire [7:0]  ccr_in,
  input wire        start,
  input wire [7:0]  mem_rdata,
  input wire [15:0] mem_addr,
  input wire [7:0]  mem_wdata,
  input wire        mem_read_write,
  input wire [15:0] pc_out,
  input wire [7:0]  condition_code_reg,
  input wire        busy,
  input wire        done,
  input wire        illegal_op
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  reg [7:0]  prev1, prev2, wval, ccr_at;
  reg [15:0] a1, a2;
  reg        wrote;
  // last two real reads, the written byte and the codes given at start
  always @(posedge ref_clk)
  begin
    if (start && !busy)
    begin
      wrote  <= 1'b0;
      ccr_at <= ccr_in;
    end
    if (busy && mem_read_write && mem_addr != 16'hffff)
    begin
      prev2 <= prev1;
      prev1 <= mem_rdata;
      a2    <= a1;
      a1    <= mem_addr;
    end
    if (!mem_read_write)
    begin
      wrote <= 1'b1;
      wval  <= mem_wdata;
    end
  end
  sequence s_never_fetch;
    start && !busy ##1 mem_rdata == 8'h21 && mem_addr == $past(start_pc);
  endsequence
  sequence s_never_tail;
    mem_addr == $past(mem_addr) + 16'h0001 ##1 mem_addr == 16'hffff && mem_read_write
      ##2 done && pc_out == $past(start_pc, 5) + 16'h0002;
  endsequence
  property p_first_fetch;
    start && !busy |=> mem_addr == $past(start_pc) && mem_read_write;
  endproperty
  property p_second_fetch;
    start && !busy ##1 1'b1 |=> mem_addr == $past(start_pc, 2) + 16'h0001;
  endproperty
  property p_dummy_read;
    busy && mem_addr == 16'hffff |-> mem_read_write;
  endproperty
  property p_never_walk;
    s_never_fetch |=> s_never_tail;
  endproperty
  property p_flags_kept;
    done && !wrote |-> condition_code_reg == ccr_at;
  endproperty
  property p_set_flags;
    done && wrote |-> condition_code_reg[3] == wval[7] && condition_code_reg[2] == (wval == 8'h00)
      && !condition_code_reg[1];
  endproperty
  property p_or_write;
    !mem_read_write |-> mem_wdata == (prev1 | prev2) && mem_addr == a2;
  endproperty
  property p_done_end;
    $fell(busy) |-> done ##1 !done;
  endproperty
  a_first_fetch: assert property (p_first_fetch) else $error("bad first fetch");
  a_second_fetch: assert property (p_second_fetch) else $error("bad second fetch");
  a_dummy_read: assert property (p_dummy_read) else $error("dummy cycle writes");
  a_never_walk: assert property (p_never_walk) else $error("bad never walk");
  a_flags_kept: assert property (p_flags_kept) else $error("codes changed");
  a_set_flags: assert property (p_set_flags) else $error("bad set flags");
  a_or_write: assert property (p_or_write) else $error("bad write back");
  a_done_end: assert property (p_done_end) else $error("bad done pulse");
endmodule // bit_test_branch_exec_properties
`default_nettype wire

// ==== verif/bus_memory_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module bus_memory_model
(
  input  wire        ref_clk,
  input  wire [15:0] mem_addr,
  input  wire [7:0]  mem_wdata,
  input  wire        mem_read_write,
  output logic [7:0] mem_rdata
);
  logic [7:0] m [0:65535];
  logic [7:0] noise = 8'h5a;
  // same-cycle read; the dummy address gives a byte that moves each cycle
  assign mem_rdata = (mem_addr == 16'hffff) ? noise : m[mem_addr];
  // write cycles store the byte
  always @(posedge ref_clk)
  begin
    noise <= ~noise + 8'h1d;
    if (!mem_read_write)
      m[mem_addr] <= mem_wdata;
  end
endmodule // bus_memory_model
`default_nettype wire

// ==== verif/test_bit_test_branch_exec.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_bit_test_branch_exec;
  logic        ref_clk = 1'b0, rst = 1'b1, start = 1'b0;
  logic [15:0] start_pc = 16'h0, index_x = 16'h0, index_y = 16'h0;
  logic [7:0]  ccr_in = 8'h0;
  wire  [15:0] mem_addr, pc_out;
  wire  [7:0]  mem_rdata, mem_wdata, condition_code_reg;
  wire         mem_read_write, busy, done, illegal_op;
  int          n_fail = 0, n_checks = 0, cyc = 0;
  logic [16:0] tr [$];
  logic [16:0] ex [$];
  bit_test_branch_exec i_bit_test_branch_exec (.ref_clk, .rst, .start_pc, .index_x, .index_y,
    .ccr_in, .start, .mem_rdata, .mem_addr, .mem_wdata, .mem_read_write, .pc_out,
    .condition_code_reg, .busy, .done, .illegal_op);
  bus_memory_model i_bus_memory_model (.ref_clk, .mem_addr, .mem_wdata, .mem_read_write,
    .mem_rdata);
  // 200 MHz clock
  always #2.5 ref_clk = ~ref_clk;
  // hang guard
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_fail++;
      $display("[ERR] %0t timeout", $time);
      results();
    end
  end
  task check(input logic [16:0] got, input logic [16:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task results;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // expected bus cycles: bit 16 is the read line, then the address
  task automatic expect_trace(input int kind, input int mode, input logic [15:0] op,
    input logic [15:0] p, input logic [15:0] ea);
    ex = {{1'b1, op}};
    if (mode == 2)
      ex.push_back({1'b1, op + 16'h1});
    ex.push_back({1'b1, p + 16'h1});
    if (kind == 2)
    begin
      ex.push_back(17'h1ffff);
      return;
    end
    if (mode != 0)
      ex.push_back(17'h1ffff);
    ex.push_back({1'b1, ea});
    ex.push_back({1'b1, p + 16'h2});
    if (kind == 0)
      ex.push_back({1'b1, p + 16'h3});
    ex.push_back(17'h1ffff);
    if (kind == 1)
      ex.push_back({1'b0, ea});
  endtask
  // random instructions with boundary masks and displacements
  initial
  begin
    logic [15:0] op, p, ea, ix, iy, exp_pc;
    logic [7:0]  opc, opnd, mask, rel, dd, cc, res;
    int          kind, mode, clr;
    void'($urandom(47805));
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    for (int i = 0; i < 60; i++)
    begin
      kind = $urandom_range(2);
      mode = (kind == 2) ? 0 : $urandom_range(2);
      clr = $urandom_range(1);
      op = 16'h1000 + 16'($urandom_range(4095));
      ix = 16'h4000 + 16'($urandom_range(16128));
      iy = 16'h8000 + 16'($urandom_range(16128));
      dd = 8'($urandom);
      opnd = 8'($urandom);
      rel = (i < 8) ? ((i & 1) ? 8'h80 : 8'h7f) : 8'($urandom);
      mask = (i % 4 == 0) ? 8'($urandom) : (i % 4 == 1) ? opnd : (i % 4 == 2) ? ~opnd : 8'h00;
      cc = 8'($urandom);
      ea = (mode == 0) ? {8'h00, dd} : (mode == 1) ? ix + 16'(dd) : iy + 16'(dd);
      p = op + ((mode == 2) ? 16'h1 : 16'h0);
      opc = (kind == 2) ? 8'h21 : (kind == 1) ? ((mode == 0) ? 8'h14 : 8'h1c) :
        (mode == 0) ? {7'h09, 1'(clr)} : {7'h0f, 1'(clr)};
      i_bus_memory_model.m[op] = 8'h18;
      i_bus_memory_model.m[ea] = opnd;
      i_bus_memory_model.m[p] = opc;
      i_bus_memory_model.m[p + 16'h1] = (kind == 2) ? rel : dd;
      i_bus_memory_model.m[p + 16'h2] = mask;
      i_bus_memory_model.m[p + 16'h3] = rel;
      res = opnd | mask;
      exp_pc = (kind == 2) ? op + 16'h2 : (kind == 1) ? p + 16'h3 : p + 16'h4;
      if (kind == 0 && (clr ? (opnd & mask) == 8'h00 : (~opnd & mask) == 8'h00))
        exp_pc = p + 16'h4 + {{8{rel[7]}}, rel};
      index_x <= ix;
      index_y <= iy;
      start_pc <= op;
      ccr_in <= cc;
      start <= 1'b1;
      @(posedge ref_clk);
      start <= 1'b0;
      tr = {};
      repeat (20)
      begin
        @(negedge ref_clk);
        if (busy === 1'b1)
          tr.push_back({mem_read_write, mem_addr});
        if (done === 1'b1)
          break;
      end
      expect_trace(kind, mode, op, p, ea);
      // the closing cycle before idle still shows busy on the dummy address
      ex.push_back(17'h1ffff);
      check(17'(tr.size()), 17'(ex.size()));
      foreach (ex[k]) check(tr[k], ex[k]);
      check({1'b0, pc_out}, {1'b0, exp_pc});
      check({9'h0, condition_code_reg}, {9'h0, (kind == 1) ?
        {cc[7:4], res[7], res == 8'h00, 1'b0, cc[0]} : cc});
      check({9'h0, i_bus_memory_model.m[ea]}, {9'h0, (kind == 1) ? res : opnd});
      @(posedge ref_clk);
    end
    results();
  end
endmodule // test_bit_test_branch_exec
bind bit_test_branch_exec bit_test_branch_exec_properties i_props (.ref_clk, .rst, .start_pc,
  .index_x, .index_y, .ccr_in, .start, .mem_rdata, .mem_addr, .mem_wdata, .mem_read_write,
  .pc_out, .condition_code_reg, .busy, .done, .illegal_op);
`default_nettype wire
